// [core/pump_speed_cfg.svh]
`ifndef PUMP_SPEED_CFG_SVH
`define PUMP_SPEED_CFG_SVH

// System clock and the one-second control tick.
`define CLK_FREQ_HZ        50000000
`define TICK_PERIOD_S      1
`define TICK_CYCLES        (`CLK_FREQ_HZ * `TICK_PERIOD_S)

// Kick-start: full speed for a fixed time, counted in ticks.
`define KICK_TIME_S        10
`define KICK_TICKS         (`KICK_TIME_S / `TICK_PERIOD_S)
`define KICK_LAST          4'(`KICK_TICKS - 1)

// Speed figures in percent.
`define PCT_FULL           7'h64
`define PCT_ZERO           7'h00
`define PCT_ONE            7'h01
`define RISE_DIVISOR       16'h000A

// Burst control window of ten ticks, ten percent per tick.
`define BURST_LAST         4'h9
`define BURST_WEIGHT       7'h0A

// Signal output: PWM frame of 100 steps at the chosen frequency.
`define PWM_FREQ_HZ        1000
`define PWM_PRESCALE       (`CLK_FREQ_HZ / (`PWM_FREQ_HZ * 100))
`define PWM_PRE_LAST       16'(`PWM_PRESCALE - 1)
`define PWM_PHASE_LAST     7'h63

// Adapter serial line: start, eight data bits LSB first, stop.
`define ADAPTER_BAUD       9600
`define ADAPTER_BIT_CYCLES (`CLK_FREQ_HZ / `ADAPTER_BAUD)
`define ADAPTER_FRAME_BITS 4'hA

// Register byte addresses.
`define ADDR_CTRL          5'h00
`define ADDR_LIMIT         5'h04
`define ADDR_DT_SWITCH     5'h08
`define ADDR_DT_RISE       5'h0C
`define ADDR_STATUS        5'h10

// Control register fields.
`define CTRL_RELAY         0
`define CTRL_SIGNAL        1
`define CTRL_SPEED         2
`define CTRL_ADAPTER       3
`define CTRL_SIGTYPE       4
`define CTRL_PROFILE       5
`define CTRL_MODE_HI       10
`define CTRL_MODE_LO       8

// Reset values.
`define RST_CTRL           32'h0000_0004
`define RST_MIN            7'h1E
`define RST_MAX            7'h64
`define RST_DT_ON          16'h003C
`define RST_DT_OFF         16'h0028
`define RST_DT_SET         16'h0064
`define RST_RISE           16'h0014

`endif

// [core/pump_speed_pkg.sv]
package pump_speed_pkg;

    // Operating mode of the output.
    typedef enum logic [2:0] {
        MODE_AUTO = 3'h0,
        MODE_ON   = 3'h1,
        MODE_MAX  = 3'h2,
        MODE_MIN  = 3'h3,
        MODE_OFF  = 3'h4
    } mode_t;

    // Automatic control state, one-hot.
    typedef enum logic [2:0] {
        ST_OFF  = 3'b001,
        ST_KICK = 3'b010,
        ST_RUN  = 3'b100
    } ctrl_state_t;

    typedef logic [6:0]         pct_t;
    typedef logic signed [17:0] temp_t;

endpackage

// [core/speed_signal_gen.sv]
`timescale 1ns/1ns
`include "pump_speed_cfg.svh"

module speed_signal_gen import pump_speed_pkg::*; (
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic enable,
    input  wire logic sig_level,
    input  wire pct_t duty,
    output logic      pwm_out,
    output pct_t      level_out
);

    logic [15:0] pre_cnt_ff;
    logic [6:0]  phase_ff;
    logic        pwm_ff;
    pct_t        level_ff;

    // Prescaler and phase counter form a PWM frame of 100 steps.
    always_ff @(posedge clk_sys) begin
        if (reset || pre_cnt_ff == `PWM_PRE_LAST) begin
            pre_cnt_ff <= 16'h0000;
        end else begin
            pre_cnt_ff <= pre_cnt_ff + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            phase_ff <= 7'h00;
        end else if (pre_cnt_ff == `PWM_PRE_LAST) begin
            phase_ff <= (phase_ff == `PWM_PHASE_LAST) ? 7'h00
                                                      : phase_ff + 7'h01;
        end
    end

    // PWM pin is high for duty steps out of every hundred.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pwm_ff <= 1'b0;
        end else begin
            pwm_ff <= enable && !sig_level && (phase_ff < duty);
        end
    end

    // Analogue level code, 0 to 100 for 0 to 10 V.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            level_ff <= `PCT_ZERO;
        end else begin
            level_ff <= (enable && sig_level) ? duty : `PCT_ZERO;
        end
    end

    assign pwm_out   = pwm_ff;
    assign level_out = level_ff;

    a_pwm_level_excl: assert property (
        @(posedge clk_sys) disable iff (reset)
        sig_level |=> !pwm_out)
        else $error("PWM pin active in level mode.");

endmodule

// [core/pump_speed_output_control.sv]
`timescale 1ns/1ns
`include "pump_speed_cfg.svh"

module pump_speed_output_control import pump_speed_pkg::*; #(
    parameter int unsigned TICK_CYCLES = `TICK_CYCLES,
    parameter int unsigned BIT_CYCLES  = `ADAPTER_BIT_CYCLES
) (
    input  wire logic               clk_sys,
    input  wire logic               reset,
    input  wire logic [4:0]         reg_addr,
    input  wire logic [31:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [31:0]        reg_rdata,
    input  wire logic signed [15:0] delta_t,
    output logic                    relay_out,
    output logic                    pwm_out,
    output pct_t                    level_out,
    output logic                    adapter_tx
);

    logic [31:0] ctrl_ff;
    pct_t        min_ff;
    pct_t        max_ff;
    logic [15:0] dt_on_ff;
    logic [15:0] dt_off_ff;
    logic [15:0] dt_set_ff;
    logic [15:0] rise_ff;
    logic [31:0] rdata_ff;
    logic [31:0] tick_cnt_ff;
    logic        tick_ff;
    ctrl_state_t state_ff;
    logic [3:0]  kick_cnt_ff;
    pct_t        run_speed_ff;
    temp_t       ref_ff;
    pct_t        cmd_pct_ff;
    logic        demand_ff;
    logic [3:0]  burst_cnt_ff;
    logic        relay_ff;
    logic [9:0]  tx_shift_ff;
    logic [3:0]  tx_bits_ff;
    logic [31:0] tx_cnt_ff;
    logic        nxt_demand;
    pct_t        nxt_cmd_pct;
    mode_t       mode;
    logic        speed_en;
    logic        adapter_eff;
    logic        burst_mode;
    logic        burst_on;
    temp_t       dt;
    temp_t       step;
    logic        step_up;
    logic        step_down;

    // Maps a speed onto the signal curve; heating pumps run inverted.
    function automatic pct_t map_curve(input logic heating,
                                       input logic on,
                                       input pct_t pct);
        pct_t eff;
        eff = on ? pct : `PCT_ZERO;
        return heating ? pct_t'(`PCT_FULL - eff) : eff;
    endfunction

    // Decodes the mode field; unknown codes behave as off.
    function automatic mode_t decode_mode(input logic [2:0] code);
        mode_t m;
        case (code)
            3'h0:    m = MODE_AUTO;
            3'h1:    m = MODE_ON;
            3'h2:    m = MODE_MAX;
            3'h3:    m = MODE_MIN;
            default: m = MODE_OFF;
        endcase
        return m;
    endfunction

    assign mode     = decode_mode(ctrl_ff[`CTRL_MODE_HI:`CTRL_MODE_LO]);
    assign speed_en = ctrl_ff[`CTRL_SPEED];
    assign dt       = temp_t'(delta_t);
    assign step     = temp_t'(rise_ff / `RISE_DIVISOR);
    assign step_up   = (dt >= ref_ff + step) && (run_speed_ff < max_ff);
    assign step_down = (dt <= ref_ff - step) && (run_speed_ff > min_ff);

    // Adapter only counts with relay option and speed control both set.
    assign adapter_eff = ctrl_ff[`CTRL_RELAY] && speed_en
                         && ctrl_ff[`CTRL_ADAPTER];
    assign burst_mode  = ctrl_ff[`CTRL_RELAY] && speed_en
                         && !ctrl_ff[`CTRL_ADAPTER]
                         && !ctrl_ff[`CTRL_SIGNAL];
    assign burst_on    = (7'(burst_cnt_ff) * `BURST_WEIGHT) < cmd_pct_ff;

    // Register writes; software settings steer the whole block.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl_ff   <= `RST_CTRL;
            min_ff    <= `RST_MIN;
            max_ff    <= `RST_MAX;
            dt_on_ff  <= `RST_DT_ON;
            dt_off_ff <= `RST_DT_OFF;
            dt_set_ff <= `RST_DT_SET;
            rise_ff   <= `RST_RISE;
        end else if (reg_wr) begin
            case (reg_addr)
                `ADDR_CTRL: begin
                    ctrl_ff <= reg_wdata & 32'h0000_073F;
                end
                `ADDR_LIMIT: begin
                    min_ff <= reg_wdata[6:0];
                    max_ff <= reg_wdata[14:8];
                end
                `ADDR_DT_SWITCH: begin
                    dt_on_ff  <= reg_wdata[15:0];
                    dt_off_ff <= reg_wdata[31:16];
                end
                `ADDR_DT_RISE: begin
                    dt_set_ff <= reg_wdata[15:0];
                    rise_ff   <= reg_wdata[31:16];
                end
                default: begin
                end
            endcase
        end
    end

    // Read data stand for exactly one cycle after the read strobe.
    always_ff @(posedge clk_sys) begin
        if (reset || !reg_rd) begin
            rdata_ff <= 32'h0000_0000;
        end else begin
            case (reg_addr)
                `ADDR_CTRL:      rdata_ff <= ctrl_ff;
                `ADDR_LIMIT:     rdata_ff <= {17'h00000, max_ff,
                                              1'b0, min_ff};
                `ADDR_DT_SWITCH: rdata_ff <= {dt_off_ff, dt_on_ff};
                `ADDR_DT_RISE:   rdata_ff <= {rise_ff, dt_set_ff};
                `ADDR_STATUS:    rdata_ff <= {19'h00000, relay_ff,
                                              state_ff, demand_ff,
                                              1'b0, cmd_pct_ff};
                default:         rdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // One-second tick from the system clock.
    always_ff @(posedge clk_sys) begin
        if (reset || tick_cnt_ff == 32'(TICK_CYCLES - 1)) begin
            tick_cnt_ff <= 32'h0000_0000;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= (tick_cnt_ff == 32'(TICK_CYCLES - 1));
        end
    end

    // Automatic state machine; held off while a manual mode is chosen.
    always_ff @(posedge clk_sys) begin
        if (reset || mode != MODE_AUTO) begin
            state_ff    <= ST_OFF;
            kick_cnt_ff <= 4'h0;
        end else if (tick_ff) begin
            case (state_ff)
                ST_OFF: begin
                    kick_cnt_ff <= 4'h0;
                    if (dt >= temp_t'(signed'(dt_on_ff))) begin
                        state_ff <= ST_KICK;
                    end
                end
                ST_KICK: begin
                    kick_cnt_ff <= kick_cnt_ff + 4'h1;
                    if (kick_cnt_ff == `KICK_LAST) begin
                        state_ff <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (dt <= temp_t'(signed'(dt_off_ff))) begin
                        state_ff <= ST_OFF;
                    end
                end
                default: begin
                    state_ff <= ST_OFF;
                end
            endcase
        end
    end

    // Speed stepping in one percent steps against a moving reference.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            run_speed_ff <= `RST_MIN;
            ref_ff       <= temp_t'(signed'(`RST_DT_SET));
        end else if (state_ff != ST_RUN) begin
            run_speed_ff <= min_ff;
            ref_ff       <= temp_t'(signed'(dt_set_ff));
        end else if (run_speed_ff > max_ff) begin
            run_speed_ff <= max_ff;
        end else if (run_speed_ff < min_ff) begin
            run_speed_ff <= min_ff;
        end else if (tick_ff && step_up) begin
            run_speed_ff <= run_speed_ff + `PCT_ONE;
            ref_ff       <= ref_ff + step;
        end else if (tick_ff && step_down) begin
            run_speed_ff <= run_speed_ff - `PCT_ONE;
            ref_ff       <= ref_ff - step;
        end
    end

    // Commanded demand and speed for the chosen mode.
    always_comb begin
        nxt_demand  = 1'b1;
        nxt_cmd_pct = `PCT_FULL;
        case (mode)
            MODE_AUTO: begin
                nxt_demand = (state_ff != ST_OFF);
                if (state_ff == ST_OFF) begin
                    nxt_cmd_pct = `PCT_ZERO;
                end else if (state_ff == ST_RUN && speed_en) begin
                    nxt_cmd_pct = run_speed_ff;
                end
            end
            MODE_ON: begin
                nxt_cmd_pct = `PCT_FULL;
            end
            MODE_MAX: begin
                nxt_cmd_pct = speed_en ? max_ff : `PCT_FULL;
            end
            MODE_MIN: begin
                nxt_cmd_pct = speed_en ? min_ff : `PCT_FULL;
            end
            default: begin
                nxt_demand  = 1'b0;
                nxt_cmd_pct = `PCT_ZERO;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            demand_ff  <= 1'b0;
            cmd_pct_ff <= `PCT_ZERO;
        end else begin
            demand_ff  <= nxt_demand;
            cmd_pct_ff <= nxt_cmd_pct;
        end
    end

    // Burst window counted in ticks.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            burst_cnt_ff <= 4'h0;
        end else if (tick_ff) begin
            burst_cnt_ff <= (burst_cnt_ff == `BURST_LAST) ? 4'h0
                                                          : burst_cnt_ff + 4'h1;
        end
    end

    // Relay follows demand; bursts only without adapter or signal output.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            relay_ff <= 1'b0;
        end else begin
            relay_ff <= ctrl_ff[`CTRL_RELAY] && demand_ff
                        && (!burst_mode || burst_on);
        end
    end

    // Adapter frame each tick: start, demand and speed byte, stop.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tx_shift_ff <= 10'h3FF;
            tx_bits_ff  <= 4'h0;
            tx_cnt_ff   <= 32'h0000_0000;
        end else if (tx_bits_ff == 4'h0) begin
            tx_shift_ff <= 10'h3FF;
            if (tick_ff && adapter_eff) begin
                tx_shift_ff <= {1'b1, demand_ff,
                                map_curve(1'b0, demand_ff, cmd_pct_ff), 1'b0};
                tx_bits_ff  <= `ADAPTER_FRAME_BITS;
                tx_cnt_ff   <= 32'h0000_0000;
            end
        end else if (tx_cnt_ff == 32'(BIT_CYCLES - 1)) begin
            tx_shift_ff <= {1'b1, tx_shift_ff[9:1]};
            tx_bits_ff  <= tx_bits_ff - 4'h1;
            tx_cnt_ff   <= 32'h0000_0000;
        end else begin
            tx_cnt_ff <= tx_cnt_ff + 32'h0000_0001;
        end
    end

    // Signal output stage, PWM or analogue level.
    speed_signal_gen u_signal (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .enable    (ctrl_ff[`CTRL_SIGNAL]),
        .sig_level (ctrl_ff[`CTRL_SIGTYPE]),
        .duty      (map_curve(ctrl_ff[`CTRL_PROFILE], demand_ff,
                              cmd_pct_ff)),
        .pwm_out   (pwm_out),
        .level_out (level_out)
    );

    assign reg_rdata  = rdata_ff;
    assign relay_out  = relay_ff;
    assign adapter_tx = tx_shift_ff[0];

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_kick_start;
        mode == MODE_AUTO && state_ff == ST_OFF && tick_ff
            && dt >= temp_t'(signed'(dt_on_ff));
    endsequence

    sequence s_kick_end;
        mode == MODE_AUTO && state_ff == ST_KICK && tick_ff
            && kick_cnt_ff == `KICK_LAST;
    endsequence

    a_kick_full_speed: assert property (
        s_kick_start ##1 (mode == MODE_AUTO) |=> cmd_pct_ff == `PCT_FULL)
        else $error("Kick-start not at full speed.");
    a_kick_to_min: assert property (
        s_kick_end |=> state_ff == ST_RUN && run_speed_ff == min_ff)
        else $error("Speed not at minimum after kick-start.");
    a_step_up_one: assert property (
        state_ff == ST_RUN && tick_ff && step_up && mode == MODE_AUTO
        && run_speed_ff >= min_ff
        |=> run_speed_ff == $past(run_speed_ff) + `PCT_ONE)
        else $error("Speed did not rise by one step.");
    a_max_hold: assert property (
        state_ff == ST_RUN && run_speed_ff == max_ff && mode == MODE_AUTO
        && $stable(max_ff) |=> run_speed_ff <= max_ff)
        else $error("Speed rose above maximum.");
    a_step_down_one: assert property (
        state_ff == ST_RUN && tick_ff && !step_up && step_down
        && mode == MODE_AUTO && run_speed_ff <= max_ff
        |=> run_speed_ff == $past(run_speed_ff) - `PCT_ONE)
        else $error("Speed did not fall by one step.");
    a_adapter_relay: assert property (
        adapter_eff && $stable(ctrl_ff) |=> relay_out == $past(demand_ff))
        else $error("Relay not plain on/off with adapter.");
    a_manual_on: assert property (
        mode == MODE_ON |=> demand_ff && cmd_pct_ff == `PCT_FULL)
        else $error("Manual on not at full speed.");
    a_manual_max: assert property (
        mode == MODE_MAX && speed_en |=> cmd_pct_ff == $past(max_ff))
        else $error("Manual max not at maximum speed.");
    a_manual_min: assert property (
        mode == MODE_MIN && speed_en |=> cmd_pct_ff == $past(min_ff))
        else $error("Manual min not at minimum speed.");
    a_manual_off: assert property (
        mode == MODE_OFF [*2] |=> !relay_out && !demand_ff)
        else $error("Manual off left the output on.");
    a_manual_hold: assert property (
        mode != MODE_AUTO |=> state_ff == ST_OFF)
        else $error("Automatic control ran in manual mode.");
    a_adapter_ignored: assert property (
        !ctrl_ff[`CTRL_SPEED] && tx_bits_ff == 4'h0 |=> adapter_tx)
        else $error("Adapter frame sent without speed control.");
    a_run_clamped: assert property (
        state_ff == ST_RUN && $stable(min_ff) && $stable(max_ff)
        && min_ff <= max_ff ##1 state_ff == ST_RUN && $stable(min_ff)
        && $stable(max_ff) |-> run_speed_ff >= min_ff
        && run_speed_ff <= max_ff)
        else $error("Running speed outside limits.");
    a_tick_only_step: assert property (
        !tick_ff && state_ff == ST_RUN && $stable(min_ff) && $stable(max_ff)
        && run_speed_ff >= min_ff && run_speed_ff <= max_ff
        |=> $stable(run_speed_ff))
        else $error("Speed changed between ticks.");

endmodule

// [sim/pump_far_side.sv]
`timescale 1ns/1ns

module pump_far_side #(
    parameter int BIT_CYCLES = 8
) (
    input  wire logic       clk_sys,
    input  wire logic       adapter_tx,
    output logic      [7:0] rx_byte,
    output int              rx_count
);
    // Speed adapter receiver: finds a start bit, samples each bit mid-cell.
    initial begin
        rx_byte  = 8'h00;
        rx_count = 0;
        forever begin
            @(negedge adapter_tx);
            repeat (BIT_CYCLES + BIT_CYCLES / 2) @(posedge clk_sys);
            for (int i = 0; i < 8; i++) begin
                rx_byte[i] = adapter_tx;
                repeat (BIT_CYCLES) @(posedge clk_sys);
            end
            if (adapter_tx) rx_count++;
        end
    end
endmodule

// [sim/pump_speed_output_control_test.sv]
`timescale 1ns/1ns
`include "pump_speed_cfg.svh"

module pump_speed_output_control_test import pump_speed_pkg::*; ;
    localparam int TICK = 200;
    localparam int BITC = 8;
    logic               clk_sys   = 1'b0;
    logic               reset     = 1'b1;
    logic        [4:0]  reg_addr  = 5'h00;
    logic        [31:0] reg_wdata = 32'h0000_0000;
    logic               reg_wr    = 1'b0;
    logic               reg_rd    = 1'b0;
    logic        [31:0] reg_rdata;
    logic signed [15:0] delta_t   = 16'sh0000;
    logic               relay_out;
    logic               pwm_out;
    pct_t               level_out;
    logic               adapter_tx;
    logic        [7:0]  rx_byte;
    int                 rx_count;
    int                 err_total = 0;
    int                 checked   = 0;
    logic        [31:0] v;
    int                 n;

    // Clock at 50 MHz.
    always #10 clk_sys = ~clk_sys;

    pump_speed_output_control #(.TICK_CYCLES(TICK), .BIT_CYCLES(BITC)) dut_u (
        .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .delta_t(delta_t), .relay_out(relay_out),
        .pwm_out(pwm_out), .level_out(level_out), .adapter_tx(adapter_tx));

    pump_far_side #(.BIT_CYCLES(BITC)) far_u (
        .clk_sys(clk_sys), .adapter_tx(adapter_tx),
        .rx_byte(rx_byte), .rx_count(rx_count));

    // Compares one value and counts it.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    // One-cycle write strobe.
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    // One-cycle read strobe; data taken in the following cycle.
    task automatic rd(input logic [4:0] a);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // Waits a number of ticks, then reads the status word.
    task automatic status_after(input int ticks);
        repeat (ticks * TICK) @(posedge clk_sys);
        rd(`ADDR_STATUS);
    endtask

    // Applies control bits and checks the settled level and relay outputs.
    task automatic manual(input logic [2:0] m, input logic [5:0] opt,
                          input pct_t lvl, input logic rly);
        wr(`ADDR_CTRL, {21'h0, m, 2'h0, opt});
        repeat (20) @(posedge clk_sys);
        check(level_out, lvl);
        check(relay_out, rly);
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic results();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Watchdog well beyond the expected length of the run.
    initial begin
        repeat (40000) @(posedge clk_sys);
        err_total++;
        results();
    end

    initial begin
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        rd(`ADDR_CTRL);   check(v, 32'h0000_0004);
        rd(`ADDR_LIMIT);  check(v, 32'h0000_641E);
        rd(5'h14);        check(v, 32'h0000_0000);
        $display("test reset done");
        delta_t <= 16'sh003C;
        n = 0;
        do begin
            rd(`ADDR_STATUS);
            n++;
        end while (v[11:9] !== 3'b010 && n < 200);
        check(v[11:9], 3'b010);
        status_after(9);  check(v[11:0], 12'h564);
        status_after(1);  check(v[11:0], 12'h91E);
        delta_t <= 16'sh006A;
        status_after(4);  check(v[6:0], 7'h21);
        delta_t <= 16'sh0066;
        status_after(4);  check(v[6:0], 7'h1F);
        wr(`ADDR_LIMIT, 32'h0000_221E);
        delta_t <= 16'sh00C8;
        status_after(8);  check(v[6:0], 7'h22);
        delta_t <= 16'sh0028;
        status_after(2);  check(v[11:9], 3'b001);
        $display("test auto done");
        delta_t <= 16'sh00C8;
        wr(`ADDR_LIMIT, 32'h0000_501E);
        manual(MODE_ON,  6'h17, 7'h64, 1'b1);
        check(pwm_out, 1'b0);
        rd(`ADDR_STATUS); check(v[11:9], 3'b001);
        manual(MODE_MAX, 6'h17, 7'h50, 1'b1);
        manual(MODE_MIN, 6'h17, 7'h1E, 1'b1);
        manual(MODE_OFF, 6'h17, 7'h00, 1'b0);
        manual(MODE_MIN, 6'h37, 7'h46, 1'b1);
        manual(MODE_MIN, 6'h13, 7'h64, 1'b1);
        manual(MODE_ON,  6'h07, 7'h00, 1'b1);
        check(pwm_out, 1'b1);
        $display("test manual done");
        manual(MODE_ON, 6'h0D, 7'h00, 1'b1);
        status_after(2);
        check(rx_byte, 8'hE4);
        manual(MODE_ON, 6'h09, 7'h00, 1'b1);
        repeat (TICK) @(posedge clk_sys);
        n = rx_count;
        status_after(2);
        check(rx_count, n);
        check(adapter_tx, 1'b1);
        $display("test adapter done");
        // Burst relay at 30 percent: on for three ticks in every ten.
        wr(`ADDR_CTRL, 32'h0000_0305);
        repeat (20) @(posedge clk_sys);
        n = 0;
        repeat (10 * TICK) begin
            @(negedge clk_sys);
            n += relay_out;
        end
        check(n, 3 * TICK);
        $display("test burst done");
        results();
    end
endmodule
